// *** bench/ddsr_ctrl_properties.sv ***
`timescale 1ns/1ns
// ************
// port checks
// ************
module ddsr_ctrl_properties
    import ddsr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic update_pin,
    input wire ddsr_ctrl_type ctrl,
    input wire logic [7:0] osc_ctrl_word,
    input wire logic [7:0] test_timing_word,
    input wire logic update_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // last bytes written to two masters, to judge each update
    logic [7:0] osc_seen_reg;
    logic [7:0] tt_seen_reg;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            osc_seen_reg <= 8'hf8;
            tt_seen_reg <= 8'h10;
        end else begin
            if (wr_strobe && wr_addr == 4'hd) begin
                osc_seen_reg <= wr_data;
            end
            if (wr_strobe && wr_addr == 4'he) begin
                tt_seen_reg <= wr_data;
            end
        end
    end
    // pin path is slower: three sync flops before the load
    chk_addr_update:
    assert property (wr_strobe && wr_addr == 4'hf |-> ##1 update_pulse)
        else $error("no pulse after update write");
    chk_pin_update:
    assert property ($rose(update_pin) |-> ##[3:8] update_pulse)
        else $error("no pulse after update pin");
    chk_pulse_single:
    assert property (update_pulse |=> !update_pulse)
        else $error("update pulse too long");
    // working words move only as part of an update
    chk_word_hold:
    assert property ($changed(osc_ctrl_word) |-> update_pulse)
        else $error("control word moved without update");
    chk_center_hold:
    assert property ($changed(ctrl.cf_path) |-> update_pulse)
        else $error("center path moved without update");
    chk_feedback_bit:
    assert property (update_pulse |-> ctrl.feedback_en == osc_seen_reg[5]
        && osc_ctrl_word == osc_seen_reg)
        else $error("feedback enable off its bit");
    chk_serial_bit:
    assert property (update_pulse |-> ctrl.serial_path_en == osc_seen_reg[6])
        else $error("serial enable off its bit");
    chk_dac_bits:
    assert property (update_pulse |-> ctrl.dac_timing == tt_seen_reg[5:4]
        && test_timing_word == tt_seen_reg)
        else $error("dac timing off its bits");
    chk_reset_vals:
    assert property ($rose(rstn) |-> osc_ctrl_word == 8'hf8
        && ctrl.cf_path == 48'h400000000000) else $error("bad reset");
    cover property (update_pulse);
    cover property ($rose(update_pin));
    cover property (!ctrl.feedback_en);
endmodule : ddsr_ctrl_properties

bind ddsr_control_regs ddsr_ctrl_properties ddsr_ctrl_properties_i (
    .clk, .rstn, .wr_strobe, .wr_addr, .wr_data, .update_pin, .ctrl,
    .osc_ctrl_word, .test_timing_word, .update_pulse);

// *** bench/ddsr_host_model.sv ***
`timescale 1ns/1ns
// host processor on the parallel write port
module ddsr_host_model
    import ddsr_pkg::*;
(
    input wire logic clk,
    output logic wr_strobe,
    output logic [3:0] wr_addr,
    output logic [7:0] wr_data,
    output logic update_pin
);
    ddsr_wr_type w = '0;
    initial update_pin = 1'b0;
    assign {wr_strobe, wr_addr, wr_data} = w;
    // bus inverted after release so a stale byte never looks live
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk) w <= {1'b1, a, d};
        @(negedge clk) w <= {1'b0, ~a, ~d};
    endtask : wr
    // held four cycles to get through the pin filter
    task automatic pin_update();
        @(negedge clk) update_pin <= 1'b1;
        repeat (4) @(negedge clk);
        update_pin <= 1'b0;
    endtask : pin_update
    // required after each reset; unused serial path parked
    task automatic setup(input logic [7:0] tt);
        wr(4'he, tt);
        wr(4'hd, 8'hb8);
        wr(4'hf, 8'h00);
    endtask : setup
endmodule : ddsr_host_model

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import ddsr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_strobe, update_pin, update_pulse;
    logic [3:0] wr_addr;
    logic [7:0] wr_data, osc, tt;
    ddsr_ctrl_type ctrl;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    ddsr_host_model ddsr_host_model_i (.clk, .wr_strobe, .wr_addr,
        .wr_data, .update_pin);
    ddsr_control_regs ddsr_control_regs_i (.clk, .rstn, .wr_strobe,
        .wr_addr, .wr_data, .update_pin, .ctrl, .osc_ctrl_word(osc),
        .test_timing_word(tt), .update_pulse);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // master write then address 15, settled before looking
    task automatic commit(input logic [3:0] a, input logic [7:0] d);
        ddsr_host_model_i.wr(a, d);
        ddsr_host_model_i.wr(4'hf, 8'h5a);
        repeat (2) @(negedge clk);
    endtask : commit
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (20) @(negedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check(osc, 8'hf8);
        check(tt, 8'h10);
        check(ctrl.cf_path, 48'h400000000000);
        check(ctrl[4:0], 5'b01101);
    endtask : t_reset
    task automatic t_setup();
        ddsr_host_model_i.setup(8'h30);
        repeat (2) @(negedge clk);
        check(tt, 8'h30);
        check(osc, 8'hb8);
        check(ctrl[4:0], 5'b00111);
    endtask : t_setup
    // gating the center path must not lose the stored word
    task automatic t_center_gate();
        commit(4'hc, 8'h00);
        check(ctrl.cf_path, 48'h0);
        commit(4'hc, 8'h03);
        check(ctrl.cf_path, 48'h400000000000);
        check(ctrl.lsb_first, 1'b1);
    endtask : t_center_gate
    // staged masters stay hidden until the pin update
    task automatic t_staged();
        for (int i = 0; i < 6; i++) ddsr_host_model_i.wr(i[3:0], 8'(i + 1));
        ddsr_host_model_i.wr(4'hd, 8'h98);
        check(ctrl.cf_path, 48'h400000000000);
        ddsr_host_model_i.pin_update();
        repeat (3) @(negedge clk);
        check(ctrl.cf_path, 48'h060504030201);
        check(ctrl.feedback_en, 1'b0);
    endtask : t_staged
    initial begin
        t_reset();
        t_setup();
        t_center_gate();
        t_staged();
        t_reset();
        t_setup();
        tally_and_finish();
    end
    // run needs about 90 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
endmodule : testbench

// *** hdl/ddsr_byte_reg.sv ***
`timescale 1ns/1ns
// one byte of storage, loaded when selected, preset by reset
module ddsr_byte_reg
    import ddsr_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [7:0] din,
    output logic [7:0] q
);
    logic [7:0] q_reg;
    logic [7:0] q_next;

    // hold unless loaded
    always_comb begin
        q_next = load ? din : q_reg;
    end

    // synchronous active low reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_reg <= RESET_VALUE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule : ddsr_byte_reg

// *** hdl/ddsr_consts.svh ***
`ifndef DDSR_CONSTS_SVH
`define DDSR_CONSTS_SVH
// register addresses on the 4-bit write port
`define DDSR_ADDR_CF_LSB 4'h0
`define DDSR_ADDR_CF_MSB 4'h5
`define DDSR_ADDR_SERIAL_CTRL 4'hc
`define DDSR_ADDR_OSC_CTRL 4'hd
`define DDSR_ADDR_TEST_TIMING 4'he
`define DDSR_ADDR_UPDATE 4'hf
// reset values
`define DDSR_RST_CF_LOW 8'h00
`define DDSR_RST_CF_MSB 8'h40
`define DDSR_RST_SERIAL_CTRL 8'h01
`define DDSR_RST_OSC_CTRL 8'hf8
`define DDSR_RST_TEST_TIMING 8'h10
// field positions
`define DDSR_BIT_CF_ENABLE 0
`define DDSR_BIT_LSB_FIRST 1
`define DDSR_BIT_FEEDBACK_EN 5
`define DDSR_BIT_SERIAL_EN 6
`define DDSR_TT_TIMING_HI 5
`define DDSR_TT_TIMING_LO 4
`endif

// *** hdl/ddsr_control_regs.sv ***
`timescale 1ns/1ns
`include "ddsr_consts.svh"
// Operation
// R1: serial ctrl bit 1 clear shifts the serial word msb first, set lsb first; resets clear.
// R2: center enable clear zeros the center word into the accumulator, set passes it; resets set.
// R3: clearing center enable gates only the path, never the stored center bytes.
// R4: after reset the center word gives a quarter of the sample clock.
// R5: oscillator ctrl bit 6 gates the serial frequency path without touching its value; resets set.
// R6: the host should clear the serial path enable after reset when unused.
// R7: oscillator ctrl bit 5 enables accumulator feedback; clear stops accumulation; resets set.
// R8: oscillator ctrl resets to f8h and the host writes reserved bits back unchanged.
// R9: after every reset the host writes 00h or 30h to the test and timing register.
// R10: test timing bits 5:4 reset to 01b and the host only programs 11b or 00b there.
// R11: address 15 has no storage and a write to it acts as an update.
// R12: center msb resets to 40h, lower center bytes to zero.
// R13: an update copies all master registers to the working set in one cycle.
module ddsr_control_regs
    import ddsr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic update_pin,
    output ddsr_ctrl_type ctrl,
    output logic [7:0] osc_ctrl_word,
    output logic [7:0] test_timing_word,
    output logic update_pulse
);
    // ************************************************
    // master registers
    // ************************************************
    ddsr_wr_type wr;
    logic [7:0] cf_master [0:5];
    logic [7:0] serial_master;
    logic [7:0] osc_master;
    logic [7:0] tt_master;
    // write decode strobes
    logic [5:0] cf_load;
    logic serial_load;
    logic osc_load;
    logic tt_load;
    logic addr_update;
    // pin synchroniser stages and filtered level
    logic upd_meta_reg;
    logic upd_s2_reg;
    logic upd_s3_reg;
    logic upd_level_reg;
    logic upd_meta_next;
    logic upd_s2_next;
    logic upd_s3_next;
    logic upd_level_next;
    logic pin_rise;
    logic update_now;

    // port signals bundled as one write
    assign wr = '{strobe: wr_strobe, addr: wr_addr, data: wr_data};

    // one load strobe per address; 6 to 11 belong to another block
    always_comb begin
        cf_load = 6'h00;
        serial_load = 1'h0;
        osc_load = 1'h0;
        tt_load = 1'h0;
        addr_update = 1'h0;
        if (wr.strobe) begin
            if (wr.addr <= `DDSR_ADDR_CF_MSB) begin
                cf_load[wr.addr[2:0]] = 1'h1; // R3
            end else if (wr.addr == `DDSR_ADDR_SERIAL_CTRL) begin
                serial_load = 1'h1;
            end else if (wr.addr == `DDSR_ADDR_OSC_CTRL) begin
                osc_load = 1'h1;
            end else if (wr.addr == `DDSR_ADDR_TEST_TIMING) begin
                tt_load = 1'h1;
            end else if (wr.addr == `DDSR_ADDR_UPDATE) begin
                addr_update = 1'h1; // R11
            end
        end
    end

    // center bytes; storage is never cleared by the enable bit
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_cf
            ddsr_byte_reg #(
                .RESET_VALUE((gi == 5) ? `DDSR_RST_CF_MSB
                                       : `DDSR_RST_CF_LOW) // R12 R4
            ) u_cf (
                .clk(clk),
                .rstn(rstn),
                .load(cf_load[gi]), // R3
                .din(wr.data),
                .q(cf_master[gi])
            );
        end
    endgenerate

    ddsr_byte_reg #(.RESET_VALUE(`DDSR_RST_SERIAL_CTRL)) u_serial (
        .clk(clk),
        .rstn(rstn),
        .load(serial_load),
        .din(wr.data),
        .q(serial_master)
    );

    // reserved bits stored as written; host keeps them at reset value
    ddsr_byte_reg #(.RESET_VALUE(`DDSR_RST_OSC_CTRL)) u_osc ( // R8
        .clk(clk),
        .rstn(rstn),
        .load(osc_load),
        .din(wr.data),
        .q(osc_master)
    );

    ddsr_byte_reg #(.RESET_VALUE(`DDSR_RST_TEST_TIMING)) u_tt ( // R10
        .clk(clk),
        .rstn(rstn),
        .load(tt_load),
        .din(wr.data),
        .q(tt_master)
    );

    // ************************************************
    // update pin synchroniser and trigger
    // ************************************************
    // three flops; rise counted when stages two and three agree
    always_comb begin
        upd_meta_next = update_pin;
        upd_s2_next = upd_meta_reg;
        upd_s3_next = upd_s2_reg;
        upd_level_next = upd_level_reg;
        if (upd_s2_reg == upd_s3_reg) begin
            upd_level_next = upd_s3_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            upd_meta_reg <= 1'h0;
            upd_s2_reg <= 1'h0;
            upd_s3_reg <= 1'h0;
            upd_level_reg <= 1'h0;
        end else begin
            upd_meta_reg <= upd_meta_next;
            upd_s2_reg <= upd_s2_next;
            upd_s3_reg <= upd_s3_next;
            upd_level_reg <= upd_level_next;
        end
    end

    assign pin_rise = upd_level_next && !upd_level_reg;
    // no storage at 15: the write itself is the update
    assign update_now = pin_rise || addr_update; // R11

    // ************************************************
    // slave registers
    // ************************************************
    // working copies, loaded only on an update
    logic [47:0] cf_slave_reg;
    logic [47:0] cf_slave_next;
    logic [47:0] cf_path_reg;
    logic [47:0] cf_path_next;
    logic [7:0] serial_slave_reg;
    logic [7:0] serial_slave_next;
    logic [7:0] osc_slave_reg;
    logic [7:0] osc_slave_next;
    logic [7:0] tt_slave_reg;
    logic [7:0] tt_slave_next;
    logic update_reg;

    // all masters move together so settings never mix old and new
    always_comb begin
        cf_slave_next = cf_slave_reg;
        serial_slave_next = serial_slave_reg;
        osc_slave_next = osc_slave_reg;
        tt_slave_next = tt_slave_reg;
        if (update_now) begin
            cf_slave_next = {cf_master[5], cf_master[4], cf_master[3],
                             cf_master[2], cf_master[1], cf_master[0]}; // R13
            serial_slave_next = serial_master; // R13
            osc_slave_next = osc_master; // R13
            tt_slave_next = tt_master; // R13
        end
        // gate after the slave so the stored word survives
        cf_path_next = serial_slave_next[`DDSR_BIT_CF_ENABLE]
                     ? cf_slave_next : 48'h0; // R2 R3
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cf_slave_reg <= {`DDSR_RST_CF_MSB, {5{`DDSR_RST_CF_LOW}}}; // R4
            serial_slave_reg <= `DDSR_RST_SERIAL_CTRL; // R1 R2
            osc_slave_reg <= `DDSR_RST_OSC_CTRL; // R5 R7 R8
            tt_slave_reg <= `DDSR_RST_TEST_TIMING; // R10
            cf_path_reg <= {`DDSR_RST_CF_MSB, {5{`DDSR_RST_CF_LOW}}}; // R2 R4
            update_reg <= 1'h0;
        end else begin
            cf_slave_reg <= cf_slave_next;
            serial_slave_reg <= serial_slave_next;
            osc_slave_reg <= osc_slave_next;
            tt_slave_reg <= tt_slave_next;
            cf_path_reg <= cf_path_next;
            update_reg <= update_now;
        end
    end

    // ************************************************
    // datapath controls
    // ************************************************
    // gated word is registered so the datapath sees a flop output
    assign ctrl.cf_path = cf_path_reg; // R2 R3
    assign ctrl.lsb_first = serial_slave_reg[`DDSR_BIT_LSB_FIRST]; // R1
    assign ctrl.serial_path_en = osc_slave_reg[`DDSR_BIT_SERIAL_EN]; // R5
    assign ctrl.feedback_en = osc_slave_reg[`DDSR_BIT_FEEDBACK_EN]; // R7
    assign ctrl.dac_timing = tt_slave_reg[`DDSR_TT_TIMING_HI:
                                          `DDSR_TT_TIMING_LO]; // R10
    assign osc_ctrl_word = osc_slave_reg;
    assign test_timing_word = tt_slave_reg;
    assign update_pulse = update_reg;
endmodule : ddsr_control_regs

// *** hdl/ddsr_pkg.sv ***
package ddsr_pkg;
    // one host write on the parallel port
    typedef struct packed {
        logic strobe;
        logic [3:0] addr;
        logic [7:0] data;
    } ddsr_wr_type;

    // working settings seen by the synthesizer datapath
    typedef struct packed {
        logic [47:0] cf_path;
        logic lsb_first;
        logic serial_path_en;
        logic feedback_en;
        logic [1:0] dac_timing;
    } ddsr_ctrl_type;
endpackage : ddsr_pkg
